// File: design/irq_pkg.sv
`default_nettype none
package irq_pkg;
   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [7:0] OPT_ADDR = 8'hC8;
   localparam logic [7:0] STAT_ADDR = 8'hCC;
   localparam logic [7:0] OPT_RESET = 8'h00;
   localparam logic [7:0] OPT_WMASK = 8'h70;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // option register layout, bit 7 and bits 3..0 have no function
   typedef struct packed {
      logic unused_hi;
      logic src1_level_select;
      logic src2_edge_polarity;
      logic global_irq_enable;
      logic [3:0] unused_lo;
   } option_s;

   // ****************************************************************
   // core side
   // ****************************************************************
   typedef enum logic [1:0] {MODE_NORMAL, MODE_HANDLER, MODE_NMI} mode_e;

   localparam int NUM_SRC = 5;
   localparam int STACK_DEPTH = 2;
   localparam logic [11:0] VEC_SRC0 = 12'hFFC;
   localparam logic [11:0] VEC_SRC1 = 12'hFF6;
   localparam logic [11:0] VEC_SRC2 = 12'hFF4;
   localparam logic [11:0] VEC_SRC3 = 12'hFF2;
   localparam logic [11:0] VEC_SRC4 = 12'hFF0;
endpackage
`default_nettype wire

// File: design/mcu_interrupt_request_logic.sv
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mcu_interrupt_request_logic (
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite slave
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // peripheral events, active high except port_irq_line, which is active low
   input wire logic timer1_overflow,
   input wire logic timer2_overflow,
   input wire logic slow_osc_event,
   input wire logic converter_eoc,
   input wire logic serial_eot,
   input wire logic port_irq_line,
   input wire logic supply_supervisor,
   // core sequencer
   input wire logic instr_done,
   input wire logic [11:0] pc_now,
   input wire logic return_from_handler,
   input wire logic lowpower_req,
   output logic entry_pulse,
   output logic [11:0] entry_vector,
   output logic return_pulse,
   output logic [11:0] return_pc,
   output irq_pkg::mode_e flag_pair,
   output logic asleep,
   output logic wake_pulse,
   output logic lowpower_refused
);

   // ****************************************************************
   // declarations
   // ****************************************************************
   localparam int STACK_DEPTH_L = irq_pkg::STACK_DEPTH;
   irq_pkg::option_s option;
   logic aw_held, w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic [4:0] line_raw_n;
   logic [4:0] sync1_n, sync2_n, prev_n, fall, rise;
   logic nmi_pend, lat1, lat2;
   logic set1, set2, nmi_set;
   logic [4:1] mreq;
   logic mask_ok;
   logic take_nmi, take_mask, take_any;
   logic [11:0] next_vector;
   logic [11:0] saved_pc [STACK_DEPTH_L];
   irq_pkg::mode_e saved_mode [STACK_DEPTH_L];
   logic [1:0] sp;
   logic do_entry, do_return;
   logic [11:0] top_pc;
   irq_pkg::mode_e top_mode;

   // ****************************************************************
   // register bus
   // ****************************************************************
   // write channel: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= irq_pkg::RESP_OKAY;
      end else begin
         awready <= !aw_held && !(awvalid && awready) && !bvalid;
         wready <= !w_held && !(wvalid && wready) && !bvalid;
         if (awvalid && awready) begin
            aw_held <= 1'b1;
            aw_addr <= awaddr;
         end
         if (wvalid && wready) begin
            w_held <= 1'b1;
            w_data <= wdata;
            w_strb <= wstrb;
         end
         if (aw_held && w_held && !bvalid) begin
            bvalid <= 1'b1;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            if (aw_addr == irq_pkg::OPT_ADDR) begin
               bresp <= irq_pkg::RESP_OKAY;
            end else if (aw_addr == irq_pkg::STAT_ADDR) begin
               bresp <= irq_pkg::RESP_SLVERR;
            end else begin
               bresp <= irq_pkg::RESP_DECERR;
            end
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // option register, only the three live bits take a write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         option <= irq_pkg::option_s'(irq_pkg::OPT_RESET);
      end else if (aw_held && w_held && !bvalid
                   && aw_addr == irq_pkg::OPT_ADDR && w_strb[0]) begin
         option <= irq_pkg::option_s'(w_data[7:0] & irq_pkg::OPT_WMASK);
      end
   end

   // read channel: option reads as zero, status shows live state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= irq_pkg::RESP_OKAY;
      end else begin
         arready <= !rvalid && !(arvalid && arready);
         if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= 32'h0000_0000;
            rresp <= irq_pkg::RESP_OKAY;
            if (araddr == irq_pkg::STAT_ADDR) begin
               rdata <= {26'h0, asleep, flag_pair, lat2, lat1, nmi_pend};
            end else if (araddr != irq_pkg::OPT_ADDR) begin
               rresp <= irq_pkg::RESP_DECERR;
            end
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // request lines
   // ****************************************************************
   // event wiring, lines are active low
   assign line_raw_n[0] = !supply_supervisor;
   assign line_raw_n[1] = !serial_eot;
   assign line_raw_n[2] = port_irq_line;
   assign line_raw_n[3] = !(timer1_overflow || timer2_overflow
                            || slow_osc_event);
   assign line_raw_n[4] = !converter_eoc;

   // two-stage synchroniser plus edge history, per line
   genvar g;
   generate
      for (g = 0; g < irq_pkg::NUM_SRC; g++) begin : g_sync
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               sync1_n[g] <= 1'b1;
               sync2_n[g] <= 1'b1;
               prev_n[g] <= 1'b1;
            end else begin
               sync1_n[g] <= line_raw_n[g];
               sync2_n[g] <= sync1_n[g];
               prev_n[g] <= sync2_n[g];
            end
         end
         assign fall[g] = prev_n[g] && !sync2_n[g];
         assign rise[g] = !prev_n[g] && sync2_n[g];
      end
   endgenerate

   // source 1 edge latch only in falling edge mode
   assign set1 = fall[1] && !option.src1_level_select;
   assign set2 = option.src2_edge_polarity ? rise[2] : fall[2];
   assign nmi_set = fall[0];

   // ****************************************************************
   // arbitration
   // ****************************************************************
   // sources 3 and 4 straight from the line; level sampled now
   assign mreq[1] = option.src1_level_select ? !sync2_n[1] : lat1;
   assign mreq[2] = lat2;
   assign mreq[3] = !sync2_n[3];
   assign mreq[4] = !sync2_n[4];
   // global enable; blocked inside any handler
   assign mask_ok = option.global_irq_enable
                    && flag_pair == irq_pkg::MODE_NORMAL;
   // non-maskable preempts any routine but its own
   assign take_nmi = nmi_pend && flag_pair != irq_pkg::MODE_NMI;
   assign take_mask = mask_ok && (|mreq);
   assign take_any = take_nmi || take_mask;
   // taken only at an instruction end
   assign do_entry = instr_done && take_any && sp < 2'(STACK_DEPTH_L);
   assign do_return = return_from_handler && sp != 2'd0;

   always_comb begin
      if (take_nmi) begin
         next_vector = irq_pkg::VEC_SRC0;
      end else if (mreq[1]) begin
         next_vector = irq_pkg::VEC_SRC1;
      end else if (mreq[2]) begin
         next_vector = irq_pkg::VEC_SRC2;
      end else if (mreq[3]) begin
         next_vector = irq_pkg::VEC_SRC3;
      end else begin
         next_vector = irq_pkg::VEC_SRC4;
      end
   end

   // ****************************************************************
   // pending latches
   // ****************************************************************
   // non-maskable latch; single pending edge; set beats clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         nmi_pend <= 1'b0;
         lat1 <= 1'b0;
         lat2 <= 1'b0;
      end else begin
         if (nmi_set) begin
            nmi_pend <= 1'b1;
         end else if (do_entry && take_nmi) begin
            nmi_pend <= 1'b0;
         end
         if (set1) begin
            lat1 <= 1'b1;
         end else if (do_entry && !take_nmi && mreq[1]) begin
            lat1 <= 1'b0;
         end
         if (set2) begin
            lat2 <= 1'b1;
         end else if (do_entry && !take_nmi && !mreq[1] && mreq[2]) begin
            lat2 <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // entry, return and stack
   // ****************************************************************
   assign top_pc = saved_pc[1'(sp - 2'd1)];
   assign top_mode = saved_mode[1'(sp - 2'd1)];

   // push pc and load vector; pop on return
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sp <= 2'd0;
         entry_pulse <= 1'b0;
         entry_vector <= 12'h000;
         return_pulse <= 1'b0;
         return_pc <= 12'h000;
         for (int i = 0; i < STACK_DEPTH_L; i++) begin
            saved_pc[i] <= 12'h000;
            saved_mode[i] <= irq_pkg::MODE_NORMAL;
         end
      end else begin
         entry_pulse <= do_entry;
         return_pulse <= do_return && !do_entry;
         if (do_entry) begin
            saved_pc[1'(sp)] <= pc_now;
            saved_mode[1'(sp)] <= flag_pair;
            sp <= sp + 2'd1;
            entry_vector <= next_vector;
         end else if (do_return) begin
            sp <= sp - 2'd1;
            return_pc <= top_pc;
         end
      end
   end

   // flag pair follows the mode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_pair <= irq_pkg::MODE_NORMAL;
      end else if (do_entry) begin
         // automatic pair switch; always switched with the mode
         flag_pair <= take_nmi ? irq_pkg::MODE_NMI : irq_pkg::MODE_HANDLER;
      end else if (do_return) begin
         flag_pair <= top_mode;
      end
   end

   // ****************************************************************
   // low power
   // ****************************************************************
   // refuse sleep while a request would be taken now; wake needs enable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         asleep <= 1'b0;
         wake_pulse <= 1'b0;
         lowpower_refused <= 1'b0;
      end else begin
         wake_pulse <= 1'b0;
         lowpower_refused <= 1'b0;
         if (asleep) begin
            if (option.global_irq_enable && (nmi_pend || (|mreq))) begin
               asleep <= 1'b0;
               wake_pulse <= 1'b1;
            end
         end else if (lowpower_req) begin
            if (take_any) begin
               lowpower_refused <= 1'b1;
            end else begin
               asleep <= 1'b1;
            end
         end
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   gen_gate_a: assert property (
      entry_pulse && entry_vector != irq_pkg::VEC_SRC0
      |-> $past(option.global_irq_enable))
      else $error("maskable entry with global enable cleared");
   wake_gate_a: assert property (
      wake_pulse |-> $past(option.global_irq_enable))
      else $error("wake without global enable");
   nmi_clear_a: assert property (
      do_entry && take_nmi && !nmi_set |=> !nmi_pend)
      else $error("nmi latch not cleared on entry");
   edge_latch_a: assert property (
      set2 |=> lat2)
      else $error("source 2 edge not latched");
   handler_block_a: assert property (
      instr_done && flag_pair != irq_pkg::MODE_NORMAL
      |=> !(entry_pulse && entry_vector != irq_pkg::VEC_SRC0))
      else $error("maskable entry inside handler");
   src1_prio_a: assert property (
      instr_done && mask_ok && !take_nmi && lat1 && !option.src1_level_select
      && sp == 2'd0 |=> entry_pulse && entry_vector == irq_pkg::VEC_SRC1)
      else $error("source 1 not served first");
   flag_switch_a: assert property (
      entry_pulse |-> flag_pair == (entry_vector == irq_pkg::VEC_SRC0
      ? irq_pkg::MODE_NMI : irq_pkg::MODE_HANDLER))
      else $error("flag pair not switched on entry");
   pop_pc_a: assert property (
      do_return && !do_entry |=> return_pulse && return_pc == $past(top_pc))
      else $error("return pc not popped");
   sleep_refuse_a: assert property (
      lowpower_req && !asleep && take_any |=> lowpower_refused && !asleep)
      else $error("sleep accepted with pending request");
   opt_mask_a: assert property (
      (option & ~irq_pkg::option_s'(irq_pkg::OPT_WMASK)) == 8'h00)
      else $error("dead option bit set");

   nmi_entry_c: cover property (entry_pulse && flag_pair == irq_pkg::MODE_NMI);
   nested_c: cover property (entry_pulse && flag_pair == irq_pkg::MODE_NMI
      && sp == 2'd2);
   wake_c: cover property (wake_pulse);
   refuse_c: cover property (lowpower_refused);

endmodule // mcu_interrupt_request_logic
`default_nettype wire

// File: bench/core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ***********************************
// core sequencer side model
// ***********************************
module core_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic go_step,
   input wire logic go_ret,
   input wire logic go_sleep,
   input wire logic [11:0] go_pc,
   output logic instr_done,
   output logic [11:0] pc_now,
   output logic return_from_handler,
   output logic lowpower_req
);
   // one instruction end per command, pc only meaningful with it
   // lines held past sampling
   // option written, and read back only as zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         instr_done <= 1'b0;
         pc_now <= 12'h000;
         return_from_handler <= 1'b0;
         lowpower_req <= 1'b0;
      end else begin
         instr_done <= go_step;
         pc_now <= go_step ? go_pc : ~pc_now; // stale pc is scrambled
         return_from_handler <= go_ret;
         lowpower_req <= go_sleep;
      end
   end
endmodule // core_model
`default_nettype wire

// File: bench/mcu_interrupt_request_logic_test.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_interrupt_request_logic_test;
   logic aclk = 0, aresetn = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = 0, rdata;
   logic [3:0] wstrb = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [6:0] ev = 7'h20; // port line idles high
   logic go_step = 0, go_ret = 0, go_sleep = 0;
   logic [11:0] go_pc = 0, pc_now, entry_vector, return_pc;
   logic instr_done, return_from_handler, lowpower_req;
   logic entry_pulse, return_pulse, asleep, wake_pulse, lowpower_refused;
   irq_pkg::mode_e flag_pair;
   int mismatches = 0, samples_checked = 0, wakes = 0;
   always #5 aclk = ~aclk;
   always @(posedge aclk) if (wake_pulse === 1'b1) wakes++;
   mcu_interrupt_request_logic dut (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .timer1_overflow(ev[0]), .timer2_overflow(ev[1]),
      .slow_osc_event(ev[2]), .converter_eoc(ev[3]), .serial_eot(ev[4]),
      .port_irq_line(ev[5]), .supply_supervisor(ev[6]),
      .instr_done(instr_done), .pc_now(pc_now),
      .return_from_handler(return_from_handler),
      .lowpower_req(lowpower_req), .entry_pulse(entry_pulse),
      .entry_vector(entry_vector), .return_pulse(return_pulse),
      .return_pc(return_pc), .flag_pair(flag_pair), .asleep(asleep),
      .wake_pulse(wake_pulse), .lowpower_refused(lowpower_refused));
   core_model core (.aclk(aclk), .aresetn(aresetn), .go_step(go_step),
      .go_ret(go_ret), .go_sleep(go_sleep), .go_pc(go_pc),
      .instr_done(instr_done), .pc_now(pc_now),
      .return_from_handler(return_from_handler), .lowpower_req(lowpower_req));
   // ***********************************
   // compare, bus and core tasks
   // ***********************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         input logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      // wait for the answer; only the watchdog ends a hang
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 0;
         if (wready === 1'b1) wvalid <= 0;
      end while (bvalid !== 1'b1);
      chk({30'h0, bresp}, {30'h0, r});
      bready <= 0;
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
                         input logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 0;
      end while (rvalid !== 1'b1);
      chk(rdata, d);
      chk({30'h0, rresp}, {30'h0, r});
      rready <= 0;
   endtask
   task automatic cmd(input int k, input logic [11:0] pc);
      @(posedge aclk);
      go_step <= (k == 0);
      go_ret <= (k == 1);
      go_sleep <= (k == 2);
      go_pc <= pc;
      @(posedge aclk);
      go_step <= 0;
      go_ret <= 0;
      go_sleep <= 0;
      @(posedge aclk);
      #1;
   endtask
   task automatic instr(input logic [11:0] pc, input logic e,
                        input logic [11:0] v, input irq_pkg::mode_e m);
      cmd(0, pc);
      chk({31'h0, entry_pulse}, {31'h0, e});
      if (e) chk({20'h0, entry_vector}, {20'h0, v});
      if (e) chk({30'h0, flag_pair}, {30'h0, m});
   endtask
   task automatic ret(input logic [11:0] pc, input irq_pkg::mode_e m);
      cmd(1, 12'h000);
      chk({31'h0, return_pulse}, 32'h1);
      chk({20'h0, return_pc}, {20'h0, pc});
      chk({30'h0, flag_pair}, {30'h0, m});
   endtask
   task automatic sleep(input logic r);
      cmd(2, 12'h000);
      chk({31'h0, lowpower_refused}, {31'h0, r});
      chk({31'h0, asleep}, {31'h0, ~r});
   endtask
   task automatic ev_set(input int i, input logic v);
      @(posedge aclk);
      ev[i] <= v;
      repeat (5) @(posedge aclk);
   endtask
   task automatic close_out;
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #100000;
      mismatches++;
      close_out();
   end
   // ***********************************
   // test sequence
   // ***********************************
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      axi_rd(irq_pkg::OPT_ADDR, 32'h0, irq_pkg::RESP_OKAY);
      axi_rd(8'h10, 32'h0, irq_pkg::RESP_DECERR);
      axi_wr(8'h14, 32'h10, irq_pkg::RESP_DECERR);
      axi_wr(irq_pkg::STAT_ADDR, 32'h10, irq_pkg::RESP_SLVERR);
      $display("test reset done");
      ev_set(3, 1);
      instr(12'h101, 0, 12'h0, irq_pkg::MODE_NORMAL);
      ev_set(6, 1);
      instr(12'h102, 1, irq_pkg::VEC_SRC0, irq_pkg::MODE_NMI);
      ret(12'h102, irq_pkg::MODE_NORMAL);
      instr(12'h103, 0, 12'h0, irq_pkg::MODE_NORMAL);
      $display("test disabled done");
      axi_wr(irq_pkg::OPT_ADDR, 32'h9F, irq_pkg::RESP_OKAY);
      axi_rd(irq_pkg::OPT_ADDR, 32'h0, irq_pkg::RESP_OKAY);
      instr(12'h123, 1, irq_pkg::VEC_SRC4, irq_pkg::MODE_HANDLER);
      ev_set(4, 1);
      ev_set(4, 0);
      ev_set(4, 1);
      ev_set(4, 0);
      instr(12'h200, 0, 12'h0, irq_pkg::MODE_HANDLER);
      ev_set(3, 0);
      ret(12'h123, irq_pkg::MODE_NORMAL);
      instr(12'h124, 1, irq_pkg::VEC_SRC1, irq_pkg::MODE_HANDLER);
      ret(12'h124, irq_pkg::MODE_NORMAL);
      instr(12'h125, 0, 12'h0, irq_pkg::MODE_NORMAL);
      $display("test latch done");
      ev_set(5, 0);
      ev_set(0, 1);
      instr(12'h300, 1, irq_pkg::VEC_SRC2, irq_pkg::MODE_HANDLER);
      ret(12'h300, irq_pkg::MODE_NORMAL);
      for (int i = 0; i < 3; i++) begin
         ev_set(i, 1);
         instr(12'h301, 1, irq_pkg::VEC_SRC3, irq_pkg::MODE_HANDLER);
         ev_set(i, 0);
         ret(12'h301, irq_pkg::MODE_NORMAL);
      end
      axi_wr(irq_pkg::OPT_ADDR, 32'h30, irq_pkg::RESP_OKAY);
      ev_set(5, 1);
      instr(12'h400, 1, irq_pkg::VEC_SRC2, irq_pkg::MODE_HANDLER);
      ret(12'h400, irq_pkg::MODE_NORMAL);
      $display("test priority done");
      axi_wr(irq_pkg::OPT_ADDR, 32'h50, irq_pkg::RESP_OKAY);
      ev_set(4, 1);
      instr(12'h500, 1, irq_pkg::VEC_SRC1, irq_pkg::MODE_HANDLER);
      ret(12'h500, irq_pkg::MODE_NORMAL);
      instr(12'h501, 1, irq_pkg::VEC_SRC1, irq_pkg::MODE_HANDLER);
      ev_set(6, 0);
      ev_set(6, 1);
      instr(12'h600, 1, irq_pkg::VEC_SRC0, irq_pkg::MODE_NMI);
      ret(12'h600, irq_pkg::MODE_HANDLER);
      ev_set(4, 0);
      ret(12'h501, irq_pkg::MODE_NORMAL);
      $display("test nesting done");
      ev_set(3, 1);
      sleep(1);
      ev_set(3, 0);
      sleep(0);
      ev_set(3, 1);
      chk(wakes, 32'h1);
      chk({31'h0, asleep}, 32'h0);
      ev_set(3, 0);
      axi_wr(irq_pkg::OPT_ADDR, 32'h00, irq_pkg::RESP_OKAY);
      sleep(0);
      ev_set(6, 0);
      ev_set(6, 1);
      chk(wakes, 32'h1);
      axi_rd(irq_pkg::STAT_ADDR, 32'h21, irq_pkg::RESP_OKAY);
      axi_wr(irq_pkg::OPT_ADDR, 32'h10, irq_pkg::RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk(wakes, 32'h2);
      $display("test lowpower done");
      close_out();
   end
endmodule // mcu_interrupt_request_logic_test
`default_nettype wire
